// ---- vj_status_log.v ----
/*
 * Vector jump stage status, blocking decision, trip hold, ON/OFF events,
 * cumulative counters and operation log with a plain register port.
 * Assumes pick-up, blocking, time stamp and tick come from logic on clk_sys;
 * tick is a one-cycle pulse at the start of every 5 ms processing cycle.
 */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "vj_defs.vh"

module vj_status_log
#(
	parameter [21:0] TRIP_HOLD_CYC = `VJ_TRIP_MS * `VJ_CLK_KHZ
)
(
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        tick,
	input  wire        pu_trip,
	input  wire        pu_alarm,
	input  wire        blk_in,
	input  wire [47:0] ang_in,
	input  wire [47:0] mag_in,
	input  wire [2:0]  chan_ok,
	input  wire [31:0] ts_ms,
	input  wire [2:0]  set_grp,
	input  wire [4:0]  bus_addr,
	input  wire [31:0] bus_wdata,
	input  wire        bus_wr,
	input  wire        bus_rd,
	output reg  [31:0] bus_rdata_ff,
	output reg         trip_ff,
	output reg         alarm_ff,
	output reg         blocked_ff,
	output reg  [3:0]  cond_ff,
	output reg         meas_ok_ff,
	output reg  [2:0]  mode_ff,
	output reg         ev_valid_ff,
	output reg  [2:0]  ev_code_ff,
	output reg  [31:0] ev_ts_ff
);

	// ****************************************
	// Condition codes
	// ****************************************
	localparam [3:0] ST_NORMAL  = 4'h1;
	localparam [3:0] ST_BLOCKED = 4'h2;
	localparam [3:0] ST_TRIP    = 4'h4;
	localparam [3:0] ST_ALARM   = 4'h8;

	// ****************************************
	// Registers and wires
	// ****************************************
	reg  [7:0]            ctrl_ff;
	reg  [15:0]           thr_ff;
	reg  [5:0]            evmask_ff;
	reg  [3:0]            logsel_ff;
	reg                   blk_smp_ff;
	reg                   eval_ff;
	reg  [21:0]           hold_ff;
	reg  [15:0]           cnt_ff [0:2];
	reg  [5:0]            pend_ff;
	reg  [31:0]           pend_ts_ff [0:5];
	reg                   nxt_trip;
	reg                   nxt_alarm;
	reg                   nxt_blk;
	reg  [3:0]            nxt_cond;
	reg  [5:0]            ev_set;
	reg  [5:0]            ev_take;
	reg  [2:0]            ev_pick;
	reg  [1:0]            fault_ch;
	reg  [16:0]           fault_diff;
	reg  [1:0]            rec_ev;
	reg  [31:0]           rd_mux;
	wire [50:0]           diff;
	wire [47:0]           ratio;
	wire [2:0]            low;
	wire [`VJ_REC_W-1:0]  log_rd;
	wire [3:0]            log_cnt;
	wire                  stage_off;
	wire                  forced_blk;
	wire                  uv_blk;
	wire                  trip_on;
	wire                  alarm_on;
	wire                  blk_on;
	wire                  clr_cnt;
	integer               i;

	function [16:0] abs17;
		input [16:0] v;
		begin
			abs17 = v[16] ? (17'h00000 - v) : v;
		end
	endfunction

	// ****************************************
	// Measurement and record submodules
	// ****************************************
	vj_angle_track u_track
	(
		.clk_sys  (clk_sys),
		.rst      (rst),
		.tick     (tick),
		.ang_in   (ang_in),
		.mag_in   (mag_in),
		.thr      (thr_ff),
		.diff_ff  (diff),
		.ratio_ff (ratio),
		.low_ff   (low)
	);

	vj_fault_log u_log
	(
		.clk_sys  (clk_sys),
		.rst      (rst),
		.wr_en    (trip_on | alarm_on | blk_on),
		.wr_data  ({ts_ms, rec_ev, fault_ch, set_grp,
			nxt_trip ? fault_diff : 17'h00000,
			nxt_alarm ? fault_diff : 17'h00000}),
		.rd_idx   (logsel_ff),
		.rd_data  (log_rd),
		.count_ff (log_cnt)
	);

	// ****************************************
	// Decision logic
	// ****************************************
	assign stage_off  = ctrl_ff[`VJ_CTRL_MODE] == `VJ_MODE_OFF;
	assign forced_blk = ctrl_ff[`VJ_CTRL_MODE] == `VJ_MODE_BLK
		|| ctrl_ff[`VJ_CTRL_MODE] == `VJ_MODE_TBLK;
	// All-mode blocks on any low channel, any-mode only when all are low
	assign uv_blk = ctrl_ff[`VJ_CTRL_ALL] ? |(low & ctrl_ff[`VJ_CTRL_MASK])
		: ((low & ctrl_ff[`VJ_CTRL_MASK]) == ctrl_ff[`VJ_CTRL_MASK]
		&& ctrl_ff[`VJ_CTRL_MASK] != 3'h0);
	assign trip_on  = nxt_trip & ~trip_ff;
	assign alarm_on = nxt_alarm & ~alarm_ff;
	assign blk_on   = nxt_blk & ~blocked_ff;
	assign clr_cnt  = bus_wr && bus_addr == `VJ_A_CMD && bus_wdata[`VJ_CMD_CLR];

	always @*
	begin
		nxt_trip  = trip_ff;
		nxt_alarm = alarm_ff;
		nxt_blk   = blocked_ff;
		if (trip_ff && hold_ff == 22'h000001)
			nxt_trip = 1'b0;
		if (stage_off)
		begin
			nxt_trip  = 1'b0;
			nxt_alarm = 1'b0;
			nxt_blk   = 1'b0;
		end
		else if (eval_ff)
		begin
			// Blocking was sampled one cycle earlier, at the tick
			if (blk_smp_ff | uv_blk | forced_blk)
			begin
				nxt_blk   = pu_trip | pu_alarm | uv_blk | forced_blk;
				nxt_alarm = 1'b0;
			end
			else
			begin
				nxt_blk   = 1'b0;
				nxt_alarm = pu_alarm & ctrl_ff[`VJ_CTRL_ALEN];
				if (pu_trip && !trip_ff)
					nxt_trip = 1'b1;
			end
		end
		if (nxt_trip)
			nxt_cond = ST_TRIP;
		else if (nxt_alarm)
			nxt_cond = ST_ALARM;
		else if (nxt_blk)
			nxt_cond = ST_BLOCKED;
		else
			nxt_cond = ST_NORMAL;
	end

	// Faulted channel is the selected one with the largest step
	always @*
	begin
		fault_ch   = 2'h0;
		fault_diff = 17'h00000;
		for (i = 0; i < 3; i = i + 1)
		begin
			if (ctrl_ff[4+i] && abs17(diff[i*17 +: 17]) > abs17(fault_diff))
			begin
				fault_ch   = i[1:0] + 2'h1;
				fault_diff = diff[i*17 +: 17];
			end
		end
		if (trip_on)
			rec_ev = 2'h1;
		else if (alarm_on)
			rec_ev = 2'h2;
		else
			rec_ev = 2'h3;
	end

	// Event selection and one-per-cycle drain of pending events
	always @*
	begin
		ev_set = {alarm_ff & ~nxt_alarm, alarm_on, trip_ff & ~nxt_trip, trip_on,
			blocked_ff & ~nxt_blk, blk_on} & evmask_ff;
		ev_take = 6'h00;
		ev_pick = 3'h0;
		for (i = 5; i >= 0; i = i - 1)
		begin
			if (pend_ff[i])
			begin
				ev_take = 6'h01 << i;
				ev_pick = i[2:0];
			end
		end
	end

	// ****************************************
	// Stage state, counters and events
	// ****************************************
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			blk_smp_ff  <= 1'b0;
			eval_ff     <= 1'b0;
			trip_ff     <= 1'b0;
			alarm_ff    <= 1'b0;
			blocked_ff  <= 1'b0;
			cond_ff     <= ST_NORMAL;
			hold_ff     <= 22'h000000;
			meas_ok_ff  <= 1'b0;
			mode_ff     <= `VJ_MODE_ON;
			pend_ff     <= 6'h00;
			ev_valid_ff <= 1'b0;
			ev_code_ff  <= 3'h0;
			ev_ts_ff    <= 32'h00000000;
			for (i = 0; i < 6; i = i + 1)
				pend_ts_ff[i] <= 32'h00000000;
			for (i = 0; i < 3; i = i + 1)
				cnt_ff[i] <= 16'h0000;
		end
		else
		begin
			eval_ff <= tick;
			if (tick)
				blk_smp_ff <= blk_in;
			trip_ff    <= nxt_trip;
			alarm_ff   <= nxt_alarm;
			blocked_ff <= nxt_blk;
			cond_ff    <= nxt_cond;
			if (trip_on)
				hold_ff <= TRIP_HOLD_CYC;
			else if (!nxt_trip)
				hold_ff <= 22'h000000;
			else
				hold_ff <= hold_ff - 22'h000001;
			meas_ok_ff <= ctrl_ff[`VJ_CTRL_MASK] != 3'h0
				&& (chan_ok & ctrl_ff[`VJ_CTRL_MASK]) == ctrl_ff[`VJ_CTRL_MASK];
			mode_ff <= ctrl_ff[`VJ_CTRL_MODE];
			// A clear zeroes the old count and still counts an event of the same cycle
			cnt_ff[0] <= (clr_cnt ? 16'h0000 : cnt_ff[0]) + {15'h0000, alarm_on};
			cnt_ff[1] <= (clr_cnt ? 16'h0000 : cnt_ff[1]) + {15'h0000, trip_on};
			cnt_ff[2] <= (clr_cnt ? 16'h0000 : cnt_ff[2]) + {15'h0000, blk_on};
			// A new event beats the drain of the same slot
			pend_ff     <= (pend_ff & ~ev_take) | ev_set;
			for (i = 0; i < 6; i = i + 1)
				if (ev_set[i])
					pend_ts_ff[i] <= ts_ms;
			ev_valid_ff <= |pend_ff;
			ev_code_ff  <= ev_pick;
			ev_ts_ff    <= pend_ts_ff[ev_pick];
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	always @*
	begin
		rd_mux = 32'h00000000;
		case (bus_addr)
			`VJ_A_CTRL:     rd_mux = {24'h000000, ctrl_ff};
			`VJ_A_THR:      rd_mux = {16'h0000, thr_ff};
			`VJ_A_EVMASK:   rd_mux = {26'h0000000, evmask_ff};
			`VJ_A_STATUS:   rd_mux = {20'h00000, 1'b0, mode_ff, 3'h0, meas_ok_ff, cond_ff};
			`VJ_A_DIFF0:    rd_mux = {{15{diff[16]}}, diff[16:0]};
			5'h06:          rd_mux = {{15{diff[33]}}, diff[33:17]};
			5'h07:          rd_mux = {{15{diff[50]}}, diff[50:34]};
			`VJ_A_RATIO0:   rd_mux = {16'h0000, ratio[15:0]};
			5'h09:          rd_mux = {16'h0000, ratio[31:16]};
			5'h0A:          rd_mux = {16'h0000, ratio[47:32]};
			`VJ_A_CNT0:     rd_mux = {16'h0000, cnt_ff[0]};
			5'h0C:          rd_mux = {16'h0000, cnt_ff[1]};
			5'h0D:          rd_mux = {16'h0000, cnt_ff[2]};
			`VJ_A_LOGSEL:   rd_mux = {24'h000000, log_cnt, logsel_ff};
			`VJ_A_LOGTS:    rd_mux = log_rd[72:41];
			`VJ_A_LOGINFO:  rd_mux = {25'h0, log_rd[40:34]};
			`VJ_A_LOGTRIP:  rd_mux = {{15{log_rd[33]}}, log_rd[33:17]};
			`VJ_A_LOGALARM: rd_mux = {{15{log_rd[16]}}, log_rd[16:0]};
			default:        rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctrl_ff      <= `VJ_CTRL_RST;
			thr_ff       <= `VJ_THR_RST;
			evmask_ff    <= `VJ_EVM_RST;
			logsel_ff    <= 4'h0;
			bus_rdata_ff <= 32'h00000000;
		end
		else
		begin
			if (bus_wr)
			begin
				case (bus_addr)
					`VJ_A_CTRL:   ctrl_ff   <= bus_wdata[7:0];
					`VJ_A_THR:    thr_ff    <= bus_wdata[15:0];
					`VJ_A_EVMASK: evmask_ff <= bus_wdata[5:0];
					`VJ_A_LOGSEL: logsel_ff <= bus_wdata[3:0];
					default:      logsel_ff <= logsel_ff;
				endcase
			end
			bus_rdata_ff <= bus_rd ? rd_mux : 32'h00000000;
		end
	end

endmodule

// ---- vj_defs.vh ----
/*
 * Constants of the vector jump status and fault log block: register word
 * addresses, field positions, reset values, event codes and timing.
 * Assumes inclusion by bare name from every design file of the block.
 */
`ifndef VJ_DEFS_VH
`define VJ_DEFS_VH

// ****************************************
// Register word addresses
// ****************************************
`define VJ_A_CTRL      5'h00
`define VJ_A_THR       5'h01
`define VJ_A_EVMASK    5'h02
`define VJ_A_CMD       5'h03
`define VJ_A_STATUS    5'h04
`define VJ_A_DIFF0     5'h05
`define VJ_A_RATIO0    5'h08
`define VJ_A_CNT0      5'h0B
`define VJ_A_LOGSEL    5'h0E
`define VJ_A_LOGTS     5'h0F
`define VJ_A_LOGINFO   5'h10
`define VJ_A_LOGTRIP   5'h11
`define VJ_A_LOGALARM  5'h12

// ****************************************
// Fields and reset values
// ****************************************
`define VJ_CTRL_MODE   2:0
`define VJ_CTRL_ALEN   3
`define VJ_CTRL_MASK   6:4
`define VJ_CTRL_ALL    7
`define VJ_CTRL_RST    8'h70
`define VJ_THR_RST     16'h251C
`define VJ_EVM_RST     6'h3F
`define VJ_CMD_CLR     0

`define VJ_MODE_ON     3'h0
`define VJ_MODE_BLK    3'h1
`define VJ_MODE_TEST   3'h2
`define VJ_MODE_TBLK   3'h3
`define VJ_MODE_OFF    3'h4

// Event codes: bit 0 set means OFF
`define VJ_EV_BLK_ON   3'h0
`define VJ_EV_BLK_OFF  3'h1
`define VJ_EV_TRP_ON   3'h2
`define VJ_EV_TRP_OFF  3'h3
`define VJ_EV_ALM_ON   3'h4
`define VJ_EV_ALM_OFF  3'h5

// ****************************************
// Timing
// ****************************************
`define VJ_TICK_MS     5
`define VJ_WIN_MS      20
`define VJ_HIST        (`VJ_WIN_MS / `VJ_TICK_MS)
`define VJ_TRIP_MS     20
`define VJ_CLK_KHZ     100000
`define VJ_LOG_DEPTH   12
`define VJ_REC_W       73
`define VJ_PU_SCALE    17'h00064

`endif

// ---- vj_angle_track.v ----
/*
 * Per-channel angle difference over the 20 ms window and magnitude ratio
 * against the undervoltage threshold, updated on each processing tick.
 * Assumes tick is a one-cycle pulse from logic on clk_sys every 5 ms.
 */
`timescale 1ns/100ps
`include "vj_defs.vh"

module vj_angle_track
(
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        tick,
	input  wire [47:0] ang_in,
	input  wire [47:0] mag_in,
	input  wire [15:0] thr,
	output reg  [50:0] diff_ff,
	output reg  [47:0] ratio_ff,
	output reg  [2:0]  low_ff
);

	reg [15:0] hist_ff [0:3*`VJ_HIST-1];
	integer    i;
	integer    c;

	// Zero threshold would divide by zero; report full scale instead
	function [15:0] ratio_of;
		input [15:0] mag;
		input [15:0] t;
		reg   [31:0] q;
		begin
			q = ({16'h0000, mag} * 32'h00000064) / {16'h0000, t};
			if (t == 16'h0000 || q[31:16] != 16'h0000)
				ratio_of = 16'hFFFF;
			else
				ratio_of = q[15:0];
		end
	endfunction

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			diff_ff  <= 51'h0;
			ratio_ff <= 48'h0;
			low_ff   <= 3'h0;
			for (i = 0; i < 3*`VJ_HIST; i = i + 1)
				hist_ff[i] <= 16'h0000;
		end
		else if (tick)
		begin
			for (c = 0; c < 3; c = c + 1)
			begin
				// Signed 0.01 deg difference, oldest sample is 20 ms back
				diff_ff[c*17 +: 17] <= {ang_in[c*16+15], ang_in[c*16 +: 16]}
					- {hist_ff[c*`VJ_HIST+`VJ_HIST-1][15],
					hist_ff[c*`VJ_HIST+`VJ_HIST-1]};
				ratio_ff[c*16 +: 16] <= ratio_of(mag_in[c*16 +: 16], thr);
				low_ff[c]            <= mag_in[c*16 +: 16] < thr;
				hist_ff[c*`VJ_HIST]  <= ang_in[c*16 +: 16];
				for (i = 1; i < `VJ_HIST; i = i + 1)
					hist_ff[c*`VJ_HIST+i] <= hist_ff[c*`VJ_HIST+i-1];
			end
		end
	end

endmodule

// ---- vj_fault_log.v ----
/*
 * Twelve-entry operation record ring; overwrites the oldest when full and
 * reads back by chronological index, 0 being the oldest kept record.
 * Assumes wr_en is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/100ps
`include "vj_defs.vh"

module vj_fault_log
(
	input  wire                  clk_sys,
	input  wire                  rst,
	input  wire                  wr_en,
	input  wire [`VJ_REC_W-1:0]  wr_data,
	input  wire [3:0]            rd_idx,
	output wire [`VJ_REC_W-1:0]  rd_data,
	output reg  [3:0]            count_ff
);

	reg  [`VJ_REC_W-1:0] mem_ff [0:`VJ_LOG_DEPTH-1];
	reg  [3:0]           head_ff;
	wire [4:0]           pos;
	wire [3:0]           slot;
	integer              i;

	function [3:0] wrap_inc;
		input [3:0] p;
		begin
			wrap_inc = (p == 4'hB) ? 4'h0 : p + 4'h1;
		end
	endfunction

	// Oldest record sits at head once the ring is full
	assign pos     = ((count_ff == 4'hC) ? {1'b0, head_ff} : 5'h00) + {1'b0, rd_idx};
	assign slot    = (pos >= 5'h0C) ? pos[3:0] - 4'hC : pos[3:0];
	assign rd_data = (rd_idx < count_ff) ? mem_ff[slot] : {`VJ_REC_W{1'b0}};

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			head_ff  <= 4'h0;
			count_ff <= 4'h0;
			for (i = 0; i < `VJ_LOG_DEPTH; i = i + 1)
				mem_ff[i] <= {`VJ_REC_W{1'b0}};
		end
		else if (wr_en)
		begin
			mem_ff[head_ff] <= wr_data;
			head_ff         <= wrap_inc(head_ff);
			if (count_ff != 4'hC)
				count_ff <= count_ff + 4'h1;
		end
	end

endmodule

// ---- vj_status_log_props.sv ----
/*
 * Checker for vj_status_log: timing of the outputs against their causes.
 * Assumes one clock domain, clk_sys, with rst asynchronous and active high.
 */
`timescale 1ns/100ps

module vj_status_log_props
#(
	parameter [21:0] TRIP_HOLD_CYC = 22'h000032
)
(
	input wire        clk_sys,
	input wire        rst,
	input wire        tick,
	input wire        pu_trip,
	input wire        blk_in,
	input wire        bus_rd,
	input wire [31:0] bus_rdata_ff,
	input wire        trip_ff,
	input wire        alarm_ff,
	input wire        blocked_ff,
	input wire [3:0]  cond_ff,
	input wire [2:0]  mode_ff,
	input wire        ev_valid_ff,
	input wire [2:0]  ev_code_ff
);
	reg [21:0] hold_cnt_ff;

	// Length of the current trip pulse, too long to unroll as a repetition
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			hold_cnt_ff <= 22'h0;
		else if (trip_ff)
			hold_cnt_ff <= hold_cnt_ff + 22'h1;
		else
			hold_cnt_ff <= 22'h0;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_cond_onehot;
		$onehot(cond_ff);
	endproperty
	a_cond_onehot: assert property (p_cond_onehot) else $error("cond not one-hot");
	property p_cond_normal;
		cond_ff == 4'h1 |-> !(trip_ff || alarm_ff || blocked_ff);
	endproperty
	a_cond_normal: assert property (p_cond_normal) else $error("normal with output");
	property p_blk_excl;
		blocked_ff |-> !alarm_ff;
	endproperty
	a_blk_excl: assert property (p_blk_excl) else $error("alarm while blocked");
	property p_trip_cause;
		$rose(trip_ff) |-> $past(tick, 2) && $past(pu_trip, 1) && !$past(blk_in, 2);
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip without cause");
	property p_blk_cause;
		$rose(blocked_ff) |-> $past(tick, 2);
	endproperty
	a_blk_cause: assert property (p_blk_cause) else $error("block off cycle");
	property p_trip_hold;
		$fell(trip_ff) && mode_ff != 3'h4 |-> hold_cnt_ff == TRIP_HOLD_CYC;
	endproperty
	a_trip_hold: assert property (p_trip_hold) else $error("trip pulse length");
	property p_trip_max;
		trip_ff |-> hold_cnt_ff < TRIP_HOLD_CYC;
	endproperty
	a_trip_max: assert property (p_trip_max) else $error("trip held too long");
	property p_ev_code;
		ev_valid_ff |-> ev_code_ff <= 3'h5;
	endproperty
	a_ev_code: assert property (p_ev_code) else $error("bad event code");
	property p_rd_idle;
		!$past(bus_rd) |-> bus_rdata_ff == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule

bind vj_status_log vj_status_log_props #(.TRIP_HOLD_CYC(TRIP_HOLD_CYC)) i_props (.clk_sys,
	.rst, .tick, .pu_trip, .blk_in, .bus_rd, .bus_rdata_ff, .trip_ff, .alarm_ff, .blocked_ff,
	.cond_ff, .mode_ff, .ev_valid_ff, .ev_code_ff);

// ---- vj_blk_src.sv ----
/*
 * Far side: blocking matrix and event recorder.
 * Assumes blk_req changes at least one cycle before a tick.
 */
`timescale 1ns/100ps

module vj_blk_src
(
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        blk_req,
	input  wire        ev_valid_ff,
	input  wire [2:0]  ev_code_ff,
	input  wire [31:0] ev_ts_ff,
	output reg         blk_ff
);
	logic [34:0] ev_q[$];

	// Block lands one cycle after blk_req, on the edge that raises tick, one cycle before it is sampled
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			blk_ff <= 1'b0;
		else
			blk_ff <= blk_req;
	end

	always @(posedge clk_sys)
	begin
		if (ev_valid_ff === 1'b1)
			ev_q.push_back({ev_code_ff, ev_ts_ff});
	end
endmodule

// ---- vj_status_log_bench.sv ----
/*
 * Bench for vj_status_log: a model of the stage is compared at each result.
 * Assumes vj_defs.vh on the include path and vj_blk_src as far side.
 */
`timescale 1ns/100ps
`include "vj_defs.vh"

module vj_status_log_bench;
	localparam [21:0] HOLD = 22'h000032;
	reg          clk_sys   = 1'b0;
	reg          rst       = 1'b1;
	reg          tick      = 1'b0;
	reg          pu_trip   = 1'b0;
	reg          pu_alarm  = 1'b0;
	reg          blk_req   = 1'b0;
	reg  [47:0]  ang_in    = 48'h0;
	reg  [47:0]  mag_in    = 48'h0;
	reg  [2:0]   chan_ok   = 3'h7;
	reg  [31:0]  ts_ms     = 32'h0;
	reg  [2:0]   set_grp   = 3'h0;
	reg  [4:0]   bus_addr  = 5'h00;
	reg  [31:0]  bus_wdata = 32'h0;
	reg          bus_wr    = 1'b0;
	reg          bus_rd    = 1'b0;
	wire         blk_in;
	wire [31:0]  bus_rdata_ff;
	wire [31:0]  ev_ts_ff;
	wire         trip_ff;
	wire         alarm_ff;
	wire         blocked_ff;
	wire         meas_ok_ff;
	wire         ev_valid_ff;
	wire [3:0]   cond_ff;
	wire [2:0]   mode_ff;
	wire [2:0]   ev_code_ff;
	int          errors = 0;
	int          checked = 0;
	int          cyc = 0;
	int          trp = 0, alm = 0, blk = 0, n_t = 0, n_a = 0, n_b = 0;
	int          mode = 0, ctrl = 'h70, evm = 'h3F, nt = 0, ts = 0, g = 0, i, j;
	int          ha[64][3];
	int          hm[3];
	int          ms[5] = '{1, 2, 3, 0, 4};
	int          rq_ts[$];
	int          rq_inf[$];
	logic [34:0] ev_x[$];
	logic [31:0] seed = 32'h3894C050;

	vj_status_log #(.TRIP_HOLD_CYC(HOLD)) i_dut (.clk_sys, .rst, .tick, .pu_trip, .pu_alarm,
		.blk_in, .ang_in, .mag_in, .chan_ok, .ts_ms, .set_grp, .bus_addr, .bus_wdata, .bus_wr,
		.bus_rd, .bus_rdata_ff, .trip_ff, .alarm_ff, .blocked_ff, .cond_ff, .meas_ok_ff,
		.mode_ff, .ev_valid_ff, .ev_code_ff, .ev_ts_ff);
	vj_blk_src i_src (.clk_sys, .rst, .blk_req, .ev_valid_ff, .ev_code_ff, .ev_ts_ff,
		.blk_ff(blk_in));

	always #5 clk_sys = ~clk_sys;

	// ****************
	// Tasks
	// ****************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task cmp(input [31:0] got, input [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task wr(input [4:0] a, input [31:0] d);
		@(posedge clk_sys);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr    <= 1'b0;
	endtask

	task chk(input [4:0] a, input [31:0] e, input [31:0] m = 32'hFFFFFFFF);
		@(posedge clk_sys);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd   <= 1'b0;
		@(negedge clk_sys);
		cmp(bus_rdata_ff & m, e);
	endtask

	task ev(input int c, input int on);
		if (on != 0 && evm[c])
			ev_x.push_back({c[2:0], ts[31:0]});
	endtask

	// One processing cycle; the model decides as the stage should
	task tk(input int b, input int pt, input int pa, input int lo);
		int          c, uv, bk, nb, na, rt;
		logic [47:0] an, mg;
		uv = 1;
		for (c = 0; c < 3; c++)
		begin
			ha[nt][c] = int'(rnd() % 36001) - 18000;
			hm[c] = lo ? rnd() & 32'hFFF : 32'h251C + (rnd() & 32'hFFF);
			an[16 * c +: 16] = ha[nt][c][15:0];
			mg[16 * c +: 16] = hm[c][15:0];
			uv = uv & (hm[c] < 'h251C);
		end
		nt++;
		ts = ts + 5;
		g = (g + 1) % 8;
		@(posedge clk_sys) blk_req <= b[0];
		@(posedge clk_sys);
		tick    <= 1'b1;
		ang_in  <= an;
		mag_in  <= mg;
		ts_ms   <= ts;
		set_grp <= g[2:0];
		@(posedge clk_sys);
		tick     <= 1'b0;
		pu_trip  <= pt[0];
		pu_alarm <= pa[0];
		@(posedge clk_sys);
		pu_trip  <= 1'b0;
		pu_alarm <= 1'b0;
		repeat (4) @(posedge clk_sys);
		if (mode != 4)
		begin
			bk = b || uv || mode == 1 || mode == 3;
			nb = bk && (pt || pa || uv || mode == 1 || mode == 3);
			na = !bk && pa && ctrl[3];
			rt = !bk && pt && !trp;
			ev(0, nb && !blk);
			ev(1, !nb && blk);
			ev(2, rt);
			ev(4, na && !alm);
			ev(5, !na && alm);
			if (rt || (na && !alm) || (nb && !blk))
			begin
				rq_ts.push_back(ts);
				rq_inf.push_back(((rt ? 1 : (na && !alm) ? 2 : 3) << 5) | g);
				if (rq_ts.size() > 12)
				begin
					rq_ts.pop_front();
					rq_inf.pop_front();
				end
			end
			n_t += rt;
			n_a += na && !alm;
			n_b += nb && !blk;
			blk = nb;
			alm = na;
			trp = trp | rt;
		end
		@(negedge clk_sys);
		cmp({22'h0, cond_ff, mode_ff, trip_ff, alarm_ff, blocked_ff},
			((trp ? 4 : alm ? 8 : blk ? 2 : 1) << 6) | (mode << 3) | (trp << 2) | (alm << 1)
			| blk);
	endtask

	task test_done;
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			test_done;
		end
	end

	// ****************
	// Scenarios
	// ****************
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		chk(`VJ_A_CTRL, 32'h70);
		chk(`VJ_A_THR, 32'h251C);
		chk(`VJ_A_EVMASK, 32'h3F);
		chk(`VJ_A_STATUS, 32'h1, 32'hFFFFFFEF);
		wr(5'h1F, 32'hFFFF);
		chk(5'h1F, 32'h0);
		ctrl = 'h78;
		wr(`VJ_A_CTRL, ctrl);
		for (i = 0; i < 6; i++)
		begin
			tk(0, 0, 0, 0);
			for (j = 0; j < 3 && i >= 4; j++)
			begin
				chk(`VJ_A_DIFF0 + j[4:0], ha[nt - 1][j] - ha[nt - 5][j]);
				chk(`VJ_A_RATIO0 + j[4:0], hm[j] * 100 / 'h251C);
			end
		end
		chk(`VJ_A_STATUS, 32'h11);
		chan_ok <= 3'h3;
		tk(0, 0, 0, 0);
		chk(`VJ_A_STATUS, 32'h01);
		chan_ok <= 3'h7;
		tk(0, 1, 0, 0);
		chk(`VJ_A_STATUS, 32'h14);
		repeat (60) @(posedge clk_sys);
		ev(3, 1);
		trp = 0;
		tk(1, 1, 1, 0);
		chk(`VJ_A_STATUS, 32'h12);
		tk(0, 0, 0, 0);
		tk(0, 0, 0, 1);
		chk(`VJ_A_STATUS, 32'h12);
		tk(0, 0, 0, 0);
		for (i = 0; i < 5; i++)
		begin
			mode = ms[i];
			ctrl = 'h78 | mode;
			wr(`VJ_A_CTRL, ctrl);
			tk(0, mode == 4, 0, 0);
			chk(`VJ_A_STATUS, (mode << 8) | (blk ? 2 : 1), 32'hFFFFFFEF);
		end
		mode = 0;
		ctrl = 'h78;
		wr(`VJ_A_CTRL, ctrl);
		// Mask changes between rounds: ON only, OFF only, then both
		for (i = 0; i < 13; i++)
		begin
			evm = i < 4 ? 'h15 : i < 8 ? 'h2A : 'h3F;
			wr(`VJ_A_EVMASK, evm);
			tk(0, 0, 1, 0);
			tk(0, 0, 0, 0);
		end
		chk(`VJ_A_CNT0, n_a);
		chk(`VJ_A_CNT0 + 5'h1, n_t);
		chk(`VJ_A_CNT0 + 5'h2, n_b);
		wr(`VJ_A_CMD, 32'h1);
		for (j = 0; j < 3; j++)
			chk(`VJ_A_CNT0 + j[4:0], 32'h0);
		for (j = 0; j < 13; j++)
		begin
			wr(`VJ_A_LOGSEL, j);
			chk(`VJ_A_LOGSEL, j | (rq_ts.size() << 4));
			chk(`VJ_A_LOGTS, j < 12 ? rq_ts[j] : 0);
			chk(`VJ_A_LOGINFO, j < 12 ? rq_inf[j] : 0, 32'h67);
		end
		cmp(i_src.ev_q.size(), ev_x.size());
		for (i = 0; i < ev_x.size() && i < i_src.ev_q.size(); i++)
		begin
			cmp({29'h0, i_src.ev_q[i][34:32]}, {29'h0, ev_x[i][34:32]});
			cmp(i_src.ev_q[i][31:0], ev_x[i][31:0]);
		end
		test_done;
	end
endmodule
